// [isc_ctrl_regs.sv]
// Control register bank of the motion sensor with its data-ready and pin logic.
`default_nettype none
// What this block does
// - Accel mode field selects performance or averaging
// - Accel rate zero powers down, twelve max
// - Gyro mode field selects performance, sleep, low-power
// - Gyro rate zero off, one reserved
// - Reboot bit reloads memory then self-clears
// - Block update holds data until high read
// - Auto-increment advances address per byte
// - Software reset restores defaults, then clears
// - Relocation moves second-pin sources to first
// - Ready mask suppresses data-ready until settled
// - Ready pulses 65 us, else latched
// - Polarity bit sets second pin trigger level
// - Bus available time chooses four delays
// - Pin driven under I3C only if enabled
// - Gyro full scale codes, others reserved
// - Gyro lowpass enable, bandwidth when stabilization off
// - Analog hub connects pins; sensors off first
// - Analog hub ready routed to second pin
// - Dual channel writes extra data registers
// - Accel full scale two to sixteen g
module isc_ctrl_regs
    import isc_pkg::*;
#(
    parameter int DATA_READY_SIGNAL_PULSE_CYCLES = PULSE_CYC,
    parameter int BUS_TIME_1_CYCLES = BUS_T1_CYC,
    parameter int BUS_TIME_2_CYCLES = BUS_T2_CYC,
    parameter int BUS_TIME_3_CYCLES = BUS_T3_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_acc_start,
    input wire logic [7:0] i_acc_addr,
    input wire logic i_wr_stb,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_stb,
    output logic [7:0] o_rd_data,
    input wire logic i_accel_new,
    input wire logic [15:0] i_accel_data,
    input wire logic [47:0] i_dual_data,
    input wire logic i_gyro_new,
    input wire logic [15:0] i_gyro_data,
    input wire logic i_accel_settled,
    input wire logic i_gyro_settled,
    input wire logic i_reboot_done,
    input wire logic i_stab_active,
    input wire logic [1:0] i_ready_route_a,
    input wire logic i_int_a_src,
    input wire logic i_int_b_src,
    input wire logic i_temp_ready,
    input wire logic i_ah_ready,
    input wire logic i_i3c_active,
    input wire logic i_int_b_pin,
    input wire logic i_bus_idle,
    output logic [2:0] o_accel_operating_mode,
    output logic [3:0] o_accel_output_rate,
    output logic [2:0] o_gyro_operating_mode,
    output logic [3:0] o_gyro_output_rate,
    output logic [1:0] o_accel_full_scale,
    output logic [3:0] o_gyro_full_scale,
    output logic [2:0] o_accel_second_filter_cutoff,
    output logic [1:0] o_analog_input_impedance,
    output logic o_gyro_lowpass_enable,
    output logic [2:0] o_gyro_lowpass_bandwidth,
    output logic o_analog_hub_enable,
    output logic o_accel_dual_channel_enable,
    output logic o_cfg_reserved,
    output logic o_reboot_req,
    output logic o_accel_ready,
    output logic o_gyro_ready,
    output logic o_int_a,
    output logic o_int_a_oe,
    output logic o_int_b,
    output logic o_int_b_oe,
    output logic o_trigger_active,
    output logic o_bus_available
);
    logic [7:0] ctrl_reg [8];
    logic [7:0] ptr_reg;
    logic sw_rst_reg;
    logic boot_busy_reg;
    logic reboot_req_reg;
    logic [7:0] rd_data_reg;
    logic [15:0] accel_reg;
    logic [15:0] gyro_reg;
    logic [7:0] dual_reg [6];
    logic [1:0] lock_reg;
    logic [1:0] lat_reg;
    logic [12:0] pcnt_reg [2];
    logic [1:0] ready_reg;
    logic int_a_reg;
    logic int_b_reg;
    logic oe_reg;
    logic reserved_reg;
    logic [2:0] bw_reg;
    logic [1:0] trig_sync_reg;
    logic trig_reg;
    logic [1:0] idle_sync_reg;
    logic [21:0] idle_cnt_reg;
    logic avail_reg;

    wire byte_stb = i_wr_stb | i_rd_stb;
    wire ctrl_hit = (ptr_reg[7:3] == ADDR_ACCEL_MODE_RATE[7:3]);
    wire [2:0] ctrl_idx = ptr_reg[2:0];
    wire dual_hit = (ptr_reg >= ADDR_DUAL_FIRST) && (ptr_reg <= ADDR_DUAL_LAST);
    wire [2:0] dual_idx = 3'(ptr_reg - ADDR_DUAL_FIRST);
    wire wr_ctrl = i_wr_stb & ctrl_hit;
    wire wr_update = wr_ctrl && (ctrl_idx == IDX_UPDATE);
    wire block_data_update = ctrl_reg[IDX_UPDATE][POS_BDU];
    wire auto_inc = ctrl_reg[IDX_UPDATE][POS_AUTO_INC];
    wire relocate = ctrl_reg[IDX_INTBEH][POS_RELOCATE];
    wire ready_mask = ctrl_reg[IDX_INTBEH][POS_READY_MASK];
    wire temp_route = ctrl_reg[IDX_INTBEH][POS_TEMP_ROUTE];
    wire pulse_mode = ctrl_reg[IDX_INTBEH][POS_PULSE_MODE];
    wire in_polarity = ctrl_reg[IDX_INTBEH][POS_IN_POLARITY];
    wire [1:0] bus_time = ctrl_reg[IDX_INBAND][POS_BUS_TIME +: 2];
    wire int_en_i3c = ctrl_reg[IDX_INBAND][POS_INT_I3C];
    wire ah_route = ctrl_reg[IDX_ANALOG][POS_AH_ROUTE];
    wire dual_en = ctrl_reg[IDX_ASCALE][POS_DUAL_EN];
    wire [2:0] am = ctrl_reg[IDX_ACCEL][POS_MODE +: 3];
    wire [3:0] ar = ctrl_reg[IDX_ACCEL][3:0];
    wire [2:0] gm = ctrl_reg[IDX_GYRO][POS_MODE +: 3];
    wire [3:0] gr = ctrl_reg[IDX_GYRO][3:0];
    wire [3:0] gfs = ctrl_reg[IDX_GFILT][3:0];

    // Reads of the update register show the live state of the two one-shot bits.
    wire [7:0] ctrl_rd = (ctrl_idx == IDX_UPDATE) ?
        {boot_busy_reg, ctrl_reg[IDX_UPDATE][6:1], sw_rst_reg} : ctrl_reg[ctrl_idx];
    wire [7:0] rd_mux =
        ctrl_hit ? ctrl_rd :
        dual_hit ? dual_reg[dual_idx] :
        (ptr_reg == ADDR_ACCEL_OUT_L) ? accel_reg[7:0] :
        (ptr_reg == ADDR_ACCEL_OUT_H) ? accel_reg[15:8] :
        (ptr_reg == ADDR_GYRO_OUT_L) ? gyro_reg[7:0] :
        (ptr_reg == ADDR_GYRO_OUT_H) ? gyro_reg[15:8] : 8'h00;
    wire rd_acc_l = i_rd_stb && (ptr_reg == ADDR_ACCEL_OUT_L);
    wire rd_acc_h = i_rd_stb && (ptr_reg == ADDR_ACCEL_OUT_H);
    wire rd_gyr_l = i_rd_stb && (ptr_reg == ADDR_GYRO_OUT_L);
    wire rd_gyr_h = i_rd_stb && (ptr_reg == ADDR_GYRO_OUT_H);
    wire [1:0] new_smp = {i_gyro_new, i_accel_new};
    wire [1:0] rd_low = {rd_gyr_l, rd_acc_l};
    wire [1:0] rd_high = {rd_gyr_h, rd_acc_h};
    wire [1:0] settled = {i_gyro_settled, i_accel_settled};

    // Reserved codes are stored as written but flagged for the sensing logic.
    wire am_bad = (am == 3'b010) || (am == 3'b011);
    wire ar_bad = (ar > RATE_MAX);
    wire gm_bad = (gm == 3'b010) || (gm == 3'b011) || gm[2:1] == 2'b11;
    wire gr_bad = (gr > RATE_MAX) || (gr == GYRO_RATE_GAP);
    wire gfs_bad = (gfs > GYRO_FS_2000) && (gfs != GYRO_FS_4000);
    wire any_bad = am_bad | ar_bad | gm_bad | gr_bad | gfs_bad;

    wire [21:0] bus_limit =
        (bus_time == 2'b00) ? 22'(BUS_T0_CYC) :
        (bus_time == 2'b01) ? 22'(BUS_TIME_1_CYCLES) :
        (bus_time == 2'b10) ? 22'(BUS_TIME_2_CYCLES) : 22'(BUS_TIME_3_CYCLES);

    logic [1:0] ready_raw;
    logic [1:0] ready_pin;
    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_ready
            assign ready_raw[s] = pulse_mode ? (pcnt_reg[s] != 13'h0000) : lat_reg[s];
            assign ready_pin[s] = ready_raw[s] & ~(ready_mask & ~settled[s]);
            always_ff @(posedge i_ref_clk)
            begin
                if (i_sys_rst)
                begin
                    lat_reg[s] <= 1'b0;
                    lock_reg[s] <= 1'b0;
                    pcnt_reg[s] <= 13'h0000;
                end
                else
                begin
                    // A new sample arriving with the high-byte read keeps the flag set.
                    if (new_smp[s])
                        lat_reg[s] <= 1'b1;
                    else if (rd_high[s])
                        lat_reg[s] <= 1'b0;
                    if (rd_high[s])
                        lock_reg[s] <= 1'b0;
                    else if (rd_low[s] && block_data_update)
                        lock_reg[s] <= 1'b1;
                    if (new_smp[s])
                        pcnt_reg[s] <= 13'(DATA_READY_SIGNAL_PULSE_CYCLES);
                    else if (pcnt_reg[s] != 13'h0000)
                        pcnt_reg[s] <= pcnt_reg[s] - 13'h0001;
                end
            end
        end
    endgenerate

    wire b_src = i_int_b_src | (temp_route & i_temp_ready) | (ah_route & i_ah_ready);
    wire int_a_next = (|(ready_pin & i_ready_route_a)) | i_int_a_src | (relocate & b_src);
    wire int_b_next = ~relocate & b_src;

    always_ff @(posedge i_ref_clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (i_sys_rst || sw_rst_reg)
                ctrl_reg[i] <= CTRL_RESET[i];
            else if (wr_ctrl && ctrl_idx == 3'(i))
                ctrl_reg[i] <= i_wr_data & CTRL_WMASK[i];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ptr_reg <= 8'h00;
            sw_rst_reg <= 1'b0;
            boot_busy_reg <= 1'b0;
            reboot_req_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            if (i_acc_start)
                ptr_reg <= i_acc_addr;
            else if (byte_stb && auto_inc)
                ptr_reg <= ptr_reg + 8'h01;
            sw_rst_reg <= wr_update & i_wr_data[POS_SOFTWARE_RESET_BIT] & ~sw_rst_reg;
            reboot_req_reg <= wr_update & i_wr_data[POS_REBOOT] & ~boot_busy_reg;
            if (wr_update && i_wr_data[POS_REBOOT])
                boot_busy_reg <= 1'b1;
            else if (i_reboot_done)
                boot_busy_reg <= 1'b0;
            if (i_rd_stb)
                rd_data_reg <= rd_mux;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            accel_reg <= 16'h0000;
            gyro_reg <= 16'h0000;
            for (int k = 0; k < 6; k++)
                dual_reg[k] <= 8'h00;
        end
        else
        begin
            // With block update on, a half-read word is frozen until its high byte goes.
            if (i_accel_new && !(block_data_update && lock_reg[0]))
                accel_reg <= i_accel_data;
            if (i_gyro_new && !(block_data_update && lock_reg[1]))
                gyro_reg <= i_gyro_data;
            for (int k = 0; k < 6; k++)
            begin
                if (i_accel_new && dual_en)
                    dual_reg[k] <= i_dual_data[8*k +: 8];
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ready_reg <= 2'b00;
            int_a_reg <= 1'b0;
            int_b_reg <= 1'b0;
            oe_reg <= 1'b0;
            reserved_reg <= 1'b0;
            bw_reg <= 3'h0;
            trig_sync_reg <= 2'b00;
            trig_reg <= 1'b0;
            idle_sync_reg <= 2'b00;
            idle_cnt_reg <= 22'h00_0000;
            avail_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= ready_pin;
            int_a_reg <= int_a_next;
            int_b_reg <= int_b_next;
            oe_reg <= ~i_i3c_active | int_en_i3c;
            reserved_reg <= any_bad;
            // Bandwidth choice is overridden while a stabilization chain owns the filter.
            bw_reg <= i_stab_active ? 3'h0 : ctrl_reg[IDX_GFILT][POS_LPF_BW +: 3];
            trig_sync_reg <= {trig_sync_reg[0], i_int_b_pin};
            trig_reg <= in_polarity ? trig_sync_reg[1] : ~trig_sync_reg[1];
            idle_sync_reg <= {idle_sync_reg[0], i_bus_idle};
            if (!idle_sync_reg[1])
                idle_cnt_reg <= 22'h00_0000;
            else if (idle_cnt_reg < bus_limit)
                idle_cnt_reg <= idle_cnt_reg + 22'h00_0001;
            avail_reg <= idle_sync_reg[1] && (idle_cnt_reg >= bus_limit);
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_accel_operating_mode = am;
    assign o_accel_output_rate = ar;
    assign o_gyro_operating_mode = gm;
    assign o_gyro_output_rate = gr;
    assign o_accel_full_scale = ctrl_reg[IDX_ASCALE][1:0];
    assign o_gyro_full_scale = gfs;
    assign o_accel_second_filter_cutoff = ctrl_reg[IDX_ASCALE][POS_A_CUTOFF +: 3];
    assign o_analog_input_impedance = ctrl_reg[IDX_ANALOG][POS_AH_IMPED +: 2];
    assign o_gyro_lowpass_enable = ctrl_reg[IDX_ANALOG][POS_LPF_EN];
    assign o_gyro_lowpass_bandwidth = bw_reg;
    assign o_analog_hub_enable = ctrl_reg[IDX_ANALOG][POS_AH_ENABLE];
    assign o_accel_dual_channel_enable = dual_en;
    assign o_cfg_reserved = reserved_reg;
    assign o_reboot_req = reboot_req_reg;
    assign o_accel_ready = ready_reg[0];
    assign o_gyro_ready = ready_reg[1];
    assign o_int_a = int_a_reg;
    assign o_int_a_oe = oe_reg;
    assign o_int_b = int_b_reg;
    assign o_int_b_oe = oe_reg;
    assign o_trigger_active = trig_reg;
    assign o_bus_available = avail_reg;

    a_swrst_defaults: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        sw_rst_reg |=> ctrl_reg[IDX_UPDATE] == CTRL_RESET[IDX_UPDATE]
            && ctrl_reg[IDX_INBAND] == CTRL_RESET[IDX_INBAND])
        else $error("software reset did not restore defaults");
    a_swrst_selfclear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        sw_rst_reg |=> !sw_rst_reg ##1 !sw_rst_reg)
        else $error("software reset bit did not clear");
    a_reboot_busy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_update && i_wr_data[POS_REBOOT]) |=> boot_busy_reg)
        else $error("reboot request not held busy");
    a_bdu_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (block_data_update && lock_reg[0]) |=> $stable(accel_reg))
        else $error("accel data changed while half read");
    a_autoinc_step: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (byte_stb && auto_inc && !i_acc_start) |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
        else $error("address did not advance");
    a_relocate_b: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (relocate && i_int_b_src) |=> o_int_a && !o_int_b)
        else $error("second pin source not moved to first pin");
    a_mask_ready: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (ready_mask && !i_accel_settled) |=> !o_accel_ready)
        else $error("accel ready shown before settling");
    a_pulse_len: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_accel_new && pulse_mode) |=> pcnt_reg[0] == 13'(DATA_READY_SIGNAL_PULSE_CYCLES))
        else $error("ready pulse length wrong");
    a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_accel_new && !pulse_mode) |=> lat_reg[0] ##1 (lat_reg[0] || $past(rd_acc_h)))
        else $error("latched ready lost before high read");
    a_i3c_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_i3c_active && !int_en_i3c) |=> !o_int_a_oe && !o_int_b_oe)
        else $error("pin driven under I3C while disabled");
    a_bus_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !idle_sync_reg[1] |=> !o_bus_available)
        else $error("bus available without idle bus");
    a_route_b: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (!relocate && ah_route && i_ah_ready) |=> o_int_b)
        else $error("hub ready missing on second pin");
    a_trig_high: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (in_polarity && trig_sync_reg[1]) |=> o_trigger_active)
        else $error("active high trigger not seen");
    a_reboot_once: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_reboot_req |=> !o_reboot_req)
        else $error("reboot request longer than one cycle");
    a_stab_bw: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_stab_active |=> o_gyro_lowpass_bandwidth == 3'h0)
        else $error("bandwidth not forced while chain active");
endmodule
`default_nettype wire

// [isc_ctrl_regs_test.sv]
// Self-checking bench of the sensor control register block.
`default_nettype none
module isc_ctrl_regs_test
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 20;
    localparam int BT [4] = '{200, 10, 20, 30};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic an = 1'b0, gn = 1'b0, gs = 1'b1, bd = 1'b0, stab = 1'b0, sb = 1'b0, ah = 1'b0;
    logic i3c = 1'b0, pin = 1'b0, idle = 1'b0, ast = 1'b1, isa = 1'b0, trd = 1'b0;
    logic [15:0] ad = 16'h0000, gd = 16'h0000, hold;
    logic [47:0] dd = 48'h0000_0000_0000;
    wire logic start, wr, rd;
    wire logic [7:0] addr, wdata;
    logic [7:0] rdata;
    logic [2:0] am, bw, gm;
    logic [3:0] gr, gfs, ar;
    logic [1:0] afs, ra = 2'b00;
    logic resv, boot, ard, grd, ia, iao, ib, ibo, trig, bav, dual;
    logic [31:0] seed = 32'h38f3_cbab;
    logic [7:0] exp_q [$];
    logic rd_seen = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int boots = 0;
    isc_host_model u_host (.i_ref_clk(clk), .o_start(start), .o_addr(addr), .o_wr(wr),
        .o_data(wdata), .o_rd(rd));
    isc_ctrl_regs #(.DATA_READY_SIGNAL_PULSE_CYCLES(PW), .BUS_TIME_1_CYCLES(BT[1]),
        .BUS_TIME_2_CYCLES(BT[2]), .BUS_TIME_3_CYCLES(BT[3])) u_dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_acc_start(start), .i_acc_addr(addr),
        .i_wr_stb(wr), .i_wr_data(wdata), .i_rd_stb(rd), .o_rd_data(rdata),
        .i_accel_new(an), .i_accel_data(ad), .i_dual_data(dd), .i_gyro_new(gn),
        .i_gyro_data(gd), .i_accel_settled(ast), .i_gyro_settled(gs), .i_reboot_done(bd),
        .i_stab_active(stab), .i_ready_route_a(ra), .i_int_a_src(isa), .i_int_b_src(sb),
        .i_temp_ready(trd), .i_ah_ready(ah), .i_i3c_active(i3c), .i_int_b_pin(pin),
        .i_bus_idle(idle), .o_accel_operating_mode(am), .o_accel_output_rate(ar),
        .o_gyro_operating_mode(gm), .o_gyro_output_rate(gr), .o_accel_full_scale(afs),
        .o_gyro_full_scale(gfs), .o_accel_second_filter_cutoff(), .o_analog_input_impedance(),
        .o_gyro_lowpass_enable(), .o_gyro_lowpass_bandwidth(bw), .o_analog_hub_enable(),
        .o_accel_dual_channel_enable(dual), .o_cfg_reserved(resv), .o_reboot_req(boot),
        .o_accel_ready(ard), .o_gyro_ready(grd), .o_int_a(ia), .o_int_a_oe(iao), .o_int_b(ib),
        .o_int_b_oe(ibo), .o_trigger_active(trig), .o_bus_available(bav));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One code lands in every mode, rate and gyro scale field at once.
    function automatic logic resv_of(input logic [3:0] c);
        return c[2:0] inside {3'h2, 3'h3, 3'h6, 3'h7} || c > 4'hC || c == 4'h1
            || !(c inside {[4'h0:4'h4], 4'hC});
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic sample(input logic g);
        @(negedge clk);
        seed = lfsr(seed);
        gn = g;
        an = !g;
        ad = seed[15:0];
        gd = seed[31:16];
        dd = {seed, seed[15:0]};
        @(negedge clk);
        an = 1'b0;
        gn = 1'b0;
    endtask
    always @(posedge clk) rd_seen <= rd;
    always @(posedge clk) if (boot === 1'b1) boots <= boots + 1;
    always @(negedge clk)
        if (rd_seen && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), rdata);
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) exp_q.push_back(CTRL_RESET[i]);
        u_host.rd(8'h10, 8);
        u_host.wr(8'h40, 8'h5A);
        exp_q.push_back(8'h00);
        u_host.rd(8'h40, 1);
        for (int c = 0; c < 16; c++)
        begin
            u_host.wr(8'h10, {1'b0, c[2:0], c[3:0]});
            u_host.wr(8'h11, {1'b0, c[2:0], c[3:0]});
            u_host.wr(8'h15, {1'b0, c[2:0], c[3:0]});
            u_host.wr(8'h17, {4'h0, c[3], 1'b0, c[1:0]});
            wait_n(2);
            chk("reserved", resv_of(c[3:0]), resv);
            chk("accel mode", c[2:0], am);
            chk("accel rate", c[3:0], ar);
            chk("gyro mode", c[2:0], gm);
            chk("gyro rate", c[3:0], gr);
            chk("gyro scale", c[3:0], gfs);
            chk("accel scale", c[1:0], afs);
            chk("dual", c[3], dual);
            chk("bandwidth", c[2:0], bw);
        end
        stab = 1'b1; // The bandwidth code left here is seven, not zero.
        wait_n(2);
        chk("bandwidth", 8'h00, bw);
        stab = 1'b0;
        u_host.wr(8'h10, 8'h34);
        u_host.wr(8'h12, 8'h40);
        repeat (3) exp_q.push_back(8'h34);
        u_host.rd(8'h10, 3);
        u_host.wr(8'h12, 8'h44);
        u_host.wr(8'h17, 8'h08);
        sample(1'b0);
        wait_n(1);
        chk("accel ready", 8'h01, ard);
        hold = ad;
        exp_q.push_back(ad[7:0]);
        u_host.rd(8'h28, 1);
        sample(1'b0);
        exp_q.push_back(hold[15:8]);
        u_host.rd(8'h29, 1);
        sample(1'b0);
        exp_q.push_back(ad[7:0]);
        exp_q.push_back(ad[15:8]);
        u_host.rd(8'h28, 2);
        wait_n(3);
        chk("accel ready", 8'h00, ard);
        for (int i = 0; i < 6; i++) exp_q.push_back(dd[8 * i +: 8]);
        u_host.rd(8'h34, 6);
        u_host.wr(8'h13, 8'h02);
        sample(1'b1);
        wait_n(1);
        chk("gyro ready", 8'h01, grd);
        wait_n(PW + 4);
        chk("gyro ready", 8'h00, grd);
        u_host.wr(8'h13, 8'h0A);
        gs = 1'b0;
        sample(1'b1);
        sample(1'b0);
        wait_n(1);
        chk("gyro ready", 8'h00, grd);
        chk("accel ready", 8'h01, ard);
        ra = 2'b01;
        wait_n(1);
        chk("pin a", 8'h01, ia);
        ast = 1'b0;
        wait_n(2);
        chk("accel ready", 8'h00, ard);
        ast = 1'b1;
        ra = 2'b00;
        gs = 1'b1;
        u_host.wr(8'h13, 8'h04);
        trd = 1'b1;
        pin = 1'b1;
        wait_n(5);
        chk("pin b", 8'h01, ib);
        chk("trigger", 8'h00, trig);
        trd = 1'b0;
        ah = 1'b1;
        u_host.wr(8'h16, 8'h40); // Hub enable stays clear while sensors run.
        wait_n(2);
        chk("pin b", 8'h01, ib);
        chk("pin a", 8'h00, ia);
        isa = 1'b1;
        wait_n(2);
        chk("pin a", 8'h01, ia);
        isa = 1'b0;
        sb = 1'b1;
        u_host.wr(8'h13, 8'h11);
        wait_n(4);
        chk("pin a", 8'h01, ia);
        chk("pin b", 8'h00, ib);
        chk("trigger", 8'h01, trig);
        i3c = 1'b1;
        wait_n(2);
        chk("pin a drive", 8'h00, iao);
        u_host.wr(8'h14, 8'h03);
        wait_n(2);
        chk("pin b drive", 8'h01, ibo);
        i3c = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            u_host.wr(8'h14, {5'h00, c[1:0], 1'b0});
            idle = 1'b0;
            wait_n(4);
            chk("bus free", 8'h00, bav);
            idle = 1'b1;
            wait_n(BT[c] / 2);
            chk("bus free", 8'h00, bav);
            wait_n(BT[c] / 2 + 6);
            chk("bus free", 8'h01, bav);
        end
        u_host.wr(8'h12, 8'h45);
        wait_n(2);
        for (int i = 0; i < 8; i++) exp_q.push_back(CTRL_RESET[i]);
        u_host.rd(8'h10, 8);
        u_host.wr(8'h10, 8'h04);
        u_host.wr(8'h12, 8'hC4); // The accelerometer runs before a reload.
        exp_q.push_back(8'hC4);
        u_host.rd(8'h12, 1);
        @(negedge clk);
        bd = 1'b1;
        @(negedge clk);
        bd = 1'b0;
        exp_q.push_back(8'h44);
        u_host.rd(8'h12, 1);
        wait_n(2);
        chk("reboot pulses", 8'h01, boots[7:0]);
        test_done();
    end
endmodule
`default_nettype wire

// [isc_host_model.sv]
// Host model that drives the register port of the sensor control block.
`default_nettype none
module isc_host_model
    import isc_pkg::*;
(
    input wire logic i_ref_clk,
    output var logic o_start = 1'b0,
    output var logic [7:0] o_addr = 8'h00,
    output var logic o_wr = 1'b0,
    output var logic [7:0] o_data = 8'h00,
    output var logic o_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic step(input logic s, input logic w, input logic r, input logic [7:0] v);
        @(negedge i_ref_clk);
        o_start = s;
        o_wr = w;
        o_rd = r;
        o_addr = v;
        o_data = v;
    endtask
    // The idle cycle after a write carries the inverse byte, so a stale value never passes for a fresh one.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a[7:3] != 5'h02) ? 8'hFF : (a[2:0] == 3'h2) ? 8'hC5 : CTRL_WMASK[a[2:0]];
        step(1'b1, 1'b0, 1'b0, a);
        step(1'b0, 1'b1, 1'b0, d & m);
        step(1'b0, 1'b0, 1'b0, ~(d & m));
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        step(1'b1, 1'b0, 1'b0, a);
        repeat (n) step(1'b0, 1'b0, 1'b1, ~a);
        step(1'b0, 1'b0, 1'b0, a);
    endtask
endmodule
`default_nettype wire

// [isc_pkg.sv]
// Constants and types of the sensor control register block.
`default_nettype none
package isc_pkg;
    localparam logic [7:0] ADDR_ACCEL_MODE_RATE = 8'h10;
    localparam logic [7:0] ADDR_GYRO_MODE_RATE = 8'h11;
    localparam logic [7:0] ADDR_DEVICE_UPDATE_RESET = 8'h12;
    localparam logic [7:0] ADDR_INTERRUPT_BEHAVIOUR = 8'h13;
    localparam logic [7:0] ADDR_INBAND_INTERRUPT_TIMING = 8'h14;
    localparam logic [7:0] ADDR_GYRO_FILTER_SCALE = 8'h15;
    localparam logic [7:0] ADDR_ANALOG_INPUT_GYRO_FILTER = 8'h16;
    localparam logic [7:0] ADDR_ACCEL_SCALE_FILTER = 8'h17;
    localparam logic [7:0] ADDR_GYRO_OUT_L = 8'h22;
    localparam logic [7:0] ADDR_GYRO_OUT_H = 8'h23;
    localparam logic [7:0] ADDR_ACCEL_OUT_L = 8'h28;
    localparam logic [7:0] ADDR_ACCEL_OUT_H = 8'h29;
    localparam logic [7:0] ADDR_DUAL_FIRST = 8'h34;
    localparam logic [7:0] ADDR_DUAL_LAST = 8'h39;
    // Indices into the control array, counted from the first control register.
    localparam logic [2:0] IDX_ACCEL = 3'h0;
    localparam logic [2:0] IDX_GYRO = 3'h1;
    localparam logic [2:0] IDX_UPDATE = 3'h2;
    localparam logic [2:0] IDX_INTBEH = 3'h3;
    localparam logic [2:0] IDX_INBAND = 3'h4;
    localparam logic [2:0] IDX_GFILT = 3'h5;
    localparam logic [2:0] IDX_ANALOG = 3'h6;
    localparam logic [2:0] IDX_ASCALE = 3'h7;
    // Field positions.
    localparam int POS_MODE = 4;
    localparam int POS_REBOOT = 7;
    localparam int POS_BDU = 6;
    localparam int POS_AUTO_INC = 2;
    localparam int POS_SOFTWARE_RESET_BIT = 0;
    localparam int POS_RELOCATE = 4;
    localparam int POS_READY_MASK = 3;
    localparam int POS_TEMP_ROUTE = 2;
    localparam int POS_PULSE_MODE = 1;
    localparam int POS_IN_POLARITY = 0;
    localparam int POS_BUS_TIME = 1;
    localparam int POS_INT_I3C = 0;
    localparam int POS_LPF_BW = 4;
    localparam int POS_AH_ENABLE = 7;
    localparam int POS_AH_ROUTE = 6;
    localparam int POS_AH_IMPED = 4;
    localparam int POS_LPF_EN = 0;
    localparam int POS_A_CUTOFF = 5;
    localparam int POS_DUAL_EN = 3;
    // Reset values and writable bits of the eight control registers.
    localparam logic [7:0] CTRL_RESET [8] =
        '{8'h00, 8'h00, 8'h44, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] CTRL_WMASK [8] =
        '{8'h7F, 8'h7F, 8'h44, 8'h1F, 8'h07, 8'h7F, 8'hF1, 8'hEB};
    typedef enum logic [2:0] {
        ISC_AM_HIGH_PERF = 3'b000,
        ISC_AM_HIGH_ACC = 3'b001,
        ISC_AM_LP2 = 3'b100,
        ISC_AM_LP4 = 3'b101,
        ISC_AM_LP8 = 3'b110,
        ISC_AM_NORMAL = 3'b111
    } isc_accel_mode_t;
    typedef enum logic [2:0] {
        ISC_GM_HIGH_PERF = 3'b000,
        ISC_GM_HIGH_ACC = 3'b001,
        ISC_GM_SLEEP = 3'b100,
        ISC_GM_LOW_POWER = 3'b101
    } isc_gyro_mode_t;
    localparam logic [3:0] RATE_MAX = 4'hC;
    localparam logic [3:0] GYRO_RATE_GAP = 4'h1;
    localparam logic [3:0] GYRO_FS_4000 = 4'hC;
    localparam logic [3:0] GYRO_FS_2000 = 4'h4;
    // Timing, in the unit of each figure.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_US = 65;
    localparam int BUS_T0_US = 2;
    localparam int BUS_T1_US = 50;
    localparam int BUS_T2_MS = 1;
    localparam int BUS_T3_MS = 25;
    localparam int PULSE_CYC = PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int BUS_T0_CYC = BUS_T0_US * 1000 / CLK_PERIOD_NS;
    localparam int BUS_T1_CYC = BUS_T1_US * 1000 / CLK_PERIOD_NS;
    localparam int BUS_T2_CYC = BUS_T2_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUS_T3_CYC = BUS_T3_MS * 1000000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire
